//--- design/sfr_regs.vh
/*
 status and fifo-flush register bank: offsets, bit positions, reset values and timing counts.
 assumes an 8-bit register space reached over a 32-bit classic wishbone slave.
*/
// How it works
// - status bit 6 shows live pattern analyzer lock while pattern checking runs
// - status bit 5 is high while a pattern validation error is present
// - pattern error bit only meaningful while pattern check enable is set
// - status bit 4 shows external oscillator lock
// - oscillator lock bit only meaningful while its detect enable is set
// - status bit 3 is high while loss of signal is present
// - status bit 2 is high while recovery loop is locked
// - status bit 1 is high while multiplier loop is locked
// - status bit 0 is high while the transmit fifo overflows
// - control bit 1 set makes overflow trigger an automatic fifo flush
// - control bit 1 clear: overflow stays until host issues manual flush
// - flush completes 8 to 10 tx clock cycles after manual bit falls
// - while manual flush bit is high the fifo is held in reset
// - latched status bit records overflow changes; irq only when enabled
`ifndef SFR_REGS_VH
`define SFR_REGS_VH
// ==========================================================
// offsets (printed indices, byte address = index * 4)
`define SFR_IDX_STATUS 8'h02
`define SFR_IDX_CTRL 8'h03
`define SFR_IDX_IRQ_STAT 8'h06
`define SFR_IDX_IRQ_MASK 8'h07
// ==========================================================
// fields
`define SFR_ST_PAT_LOCK 6
`define SFR_ST_PAT_ERR 5
`define SFR_ST_OSC_LOCK 4
`define SFR_ST_LOSS 3
`define SFR_ST_CDR_LOCK 2
`define SFR_ST_CMU_LOCK 1
`define SFR_ST_OVF 0
`define SFR_CT_AUTO 1
`define SFR_CT_MANUAL 0
`define SFR_CTRL_RESET 8'h00
`define SFR_CTRL_WMASK 8'h03
`define SFR_LIVE_MASK 8'h7F
// ==========================================================
// flush timing, in tx parallel clock cycles
`define SFR_FLUSH_MIN_CYC 8
`define SFR_FLUSH_CYC 9
`define SFR_FLUSH_MAX_CYC 10
`define SFR_AUTO_HOLD_CYC 2
`endif

//--- design/sfr_flush_ctl.v
/*
 transmit fifo flush sequencer: holds fifo reset during a manual or automatic flush
 and for a fixed tail after it. assumes tx_tick_i pulses once per tx parallel clock cycle.
*/
`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_flush_ctl #(
   parameter TAIL_CYC = `SFR_FLUSH_CYC,
   parameter AUTO_CYC = `SFR_AUTO_HOLD_CYC
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // controls
   input wire tx_tick_i,
   input wire manual_i,
   input wire auto_en_i,
   input wire ovf_i,
   // results
   output reg fifo_rst_o,
   output reg done_o
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_HOLD = 3'b010;
   localparam [2:0] ST_TAIL = 3'b100;
   reg [2:0] state_q;
   reg [3:0] cnt_q;
   reg from_auto_q;

   // ==========================================================
   // sequencer
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         from_auto_q <= 1'b0;
         fifo_rst_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (manual_i) begin
                  state_q <= ST_HOLD;
                  from_auto_q <= 1'b0;
                  fifo_rst_o <= 1'b1;
               end else if (auto_en_i && ovf_i) begin
                  state_q <= ST_HOLD;
                  from_auto_q <= 1'b1;
                  cnt_q <= AUTO_CYC[3:0];
                  fifo_rst_o <= 1'b1;
               end
            end
            ST_HOLD: begin
               fifo_rst_o <= 1'b1;
               if (from_auto_q) begin
                  if (tx_tick_i) begin
                     if (cnt_q <= 4'h1) begin
                        state_q <= ST_TAIL;
                        cnt_q <= TAIL_CYC[3:0];
                     end else begin
                        cnt_q <= cnt_q - 4'h1;
                     end
                  end
               end else if (!manual_i) begin
                  state_q <= ST_TAIL;
                  cnt_q <= TAIL_CYC[3:0];
               end
            end
            ST_TAIL: begin
               if (manual_i) begin
                  state_q <= ST_HOLD;
                  from_auto_q <= 1'b0;
               end else if (tx_tick_i) begin
                  if (cnt_q <= 4'h1) begin
                     state_q <= ST_IDLE;
                     fifo_rst_o <= 1'b0;
                     done_o <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q - 4'h1;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               fifo_rst_o <= 1'b0;
            end
         endcase
      end
   end
endmodule // sfr_flush_ctl

//--- design/sfr_top.v
/*
 status and fifo-flush register bank with classic wishbone slave and overflow interrupt.
 assumes live status inputs may be asynchronous; tx_tick_i marks tx parallel clock cycles.
*/
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_top #(
   parameter TAIL_CYC = `SFR_FLUSH_CYC
) (
   // clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // live status sources
   input wire pattern_lock_flag_i,
   input wire pattern_error_flag_i,
   input wire ext_osc_lock_flag_i,
   input wire signal_loss_flag_i,
   input wire recovery_lock_flag_i,
   input wire multiplier_lock_flag_i,
   input wire overflow_flag_i,
   // qualifying enables from other registers
   input wire pattern_check_enable_i,
   input wire ext_osc_lock_detect_enable_i,
   // fifo side
   input wire tx_tick_i,
   output reg fifo_flush_o,
   output reg flush_done_o,
   // interrupt
   output reg irq_o
);
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   reg [7:0] ctrl_q;
   reg overflow_change_status_q;
   reg overflow_irq_enable_q;
   reg ovf_prev_q;
   wire [6:0] live_raw;
   wire fifo_rst;
   wire done;
   wire [7:0] idx;
   wire req;
   wire wr;
   wire [7:0] status_val;

   assign live_raw = {pattern_lock_flag_i, pattern_error_flag_i, ext_osc_lock_flag_i,
      signal_loss_flag_i, recovery_lock_flag_i, multiplier_lock_flag_i, overflow_flag_i};
   assign idx = wb_adr_i[9:2];
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i && wb_sel_i[0];

   // ==========================================================
   // status synchronisers
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_sync
         always @(posedge clk_i) begin
            if (rst_i) begin
               sync1_q[g] <= 1'b0;
               sync2_q[g] <= 1'b0;
            end else if (ce_i) begin
               sync1_q[g] <= live_raw[g];
               sync2_q[g] <= sync1_q[g];
            end
         end
      end
   endgenerate

   // loss, recovery lock, multiplier lock and overflow bits straight through; pattern lock, pattern error and oscillator lock bits qualified by their enables
   assign status_val = {1'b0,
      sync2_q[`SFR_ST_PAT_LOCK] & pattern_check_enable_i,
      sync2_q[`SFR_ST_PAT_ERR] & pattern_check_enable_i,
      sync2_q[`SFR_ST_OSC_LOCK] & ext_osc_lock_detect_enable_i,
      sync2_q[`SFR_ST_LOSS],
      sync2_q[`SFR_ST_CDR_LOCK],
      sync2_q[`SFR_ST_CMU_LOCK],
      sync2_q[`SFR_ST_OVF]};

   // ==========================================================
   // flush sequencer
   sfr_flush_ctl #(
      .TAIL_CYC(TAIL_CYC),
      .AUTO_CYC(`SFR_AUTO_HOLD_CYC)
   ) u_flush (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .tx_tick_i(tx_tick_i),
      .manual_i(ctrl_q[`SFR_CT_MANUAL]),
      .auto_en_i(ctrl_q[`SFR_CT_AUTO]),
      .ovf_i(sync2_q[`SFR_ST_OVF]),
      .fifo_rst_o(fifo_rst),
      .done_o(done)
   );

   // ==========================================================
   // registers, bus and interrupt
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `SFR_CTRL_RESET;
         overflow_change_status_q <= 1'b0;
         overflow_irq_enable_q <= 1'b0;
         ovf_prev_q <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         fifo_flush_o <= 1'b0;
         flush_done_o <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h00000000;
         ovf_prev_q <= sync2_q[`SFR_ST_OVF];
         fifo_flush_o <= fifo_rst;
         flush_done_o <= done;
         if (req && !wb_we_i) begin
            case (idx)
               `SFR_IDX_STATUS: wb_dat_o <= {24'h000000, status_val};
               `SFR_IDX_CTRL: wb_dat_o <= {24'h000000, ctrl_q};
               `SFR_IDX_IRQ_STAT: wb_dat_o <= {31'h00000000, overflow_change_status_q};
               `SFR_IDX_IRQ_MASK: wb_dat_o <= {31'h00000000, overflow_irq_enable_q};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
         if (wr && idx == `SFR_IDX_CTRL) begin
            ctrl_q <= wb_dat_i[7:0] & `SFR_CTRL_WMASK;
         end
         if (wr && idx == `SFR_IDX_IRQ_MASK) begin
            overflow_irq_enable_q <= wb_dat_i[0];
         end
         // a change in the same cycle as the clear wins
         if (sync2_q[`SFR_ST_OVF] != ovf_prev_q) begin
            overflow_change_status_q <= 1'b1;
         end else if (wr && idx == `SFR_IDX_IRQ_STAT && wb_dat_i[0]) begin
            overflow_change_status_q <= 1'b0;
         end
         irq_o <= overflow_change_status_q & overflow_irq_enable_q;
      end
   end
endmodule // sfr_top

//--- sim/sfr_top_chk.sv
/* port assertions for the register bank.
 assumes bind to sfr_top with ce_i high. */
`timescale 1ns/1ps
module sfr_top_chk #(parameter TAIL_CYC = 9) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // bus
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // fifo and irq
   input wire overflow_flag_i,
   input wire tx_tick_i,
   input wire fifo_flush_o,
   input wire flush_done_o,
   input wire irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   wire rd = wb_ack_o && !wb_we_i;
   wire [7:0] idx = wb_adr_i[9:2];
   reg man_q, auto_q, was_q;
   reg [7:0] cnt_q;
   // mirror of control bits and tail tick count
   always @(posedge clk_i) begin
      if (rst_i) begin
         {man_q, auto_q, was_q, cnt_q} <= 11'h000;
      end else begin
         if (wr && idx == 8'h03) begin
            {auto_q, man_q} <= wb_dat_i[1:0];
         end
         was_q <= man_q || (was_q && fifo_flush_o);
         cnt_q <= !fifo_flush_o ? 8'h00 : cnt_q + {7'h00, tx_tick_i && !man_q};
      end
   end
   ctl_resv_a: assert property (rd && idx == 8'h03 |-> wb_dat_o[7:2] == 6'h00)
      else $error("ctrl reserved bits not zero");
   flush_go_a: assert property (wr && idx == 8'h03 && wb_dat_i[0] |-> ##[1:3] fifo_flush_o)
      else $error("manual flush not started");
   flush_hold_a: assert property (fifo_flush_o && man_q |=> fifo_flush_o)
      else $error("flush dropped while bit set");
   tail_len_a: assert property ($fell(fifo_flush_o) && was_q
      |-> cnt_q >= TAIL_CYC - 1 && cnt_q <= TAIL_CYC + 1)
      else $error("flush tail length wrong");
   done_mark_a: assert property ($fell(fifo_flush_o) |-> flush_done_o || $past(flush_done_o))
      else $error("flush end without done");
   no_self_a: assert property ($rose(fifo_flush_o) |-> man_q || auto_q)
      else $error("flush without cause");
   auto_go_a: assert property (auto_q && $rose(overflow_flag_i) |-> ##[2:12] fifo_flush_o)
      else $error("auto flush missing");
   irq_mask_a: assert property (wr && idx == 8'h07 && !wb_dat_i[0] |-> ##2 !irq_o)
      else $error("irq high while masked");
   man_end_c: cover property ($fell(fifo_flush_o) && was_q);
   auto_c: cover property (auto_q && $rose(fifo_flush_o));
   irq_c: cover property ($rose(irq_o));
endmodule // sfr_top_chk

//--- sim/sfr_host.sv
/* host model: classic wishbone master.
 assumes one 8-bit register per word. */
`timescale 1ns/1ps
module sfr_host (
   // clock
   input wire clk_i,
   input wire tx_tick_i,
   // bus
   input wire ack_i,
   input wire [31:0] rdat_i,
   output reg cyc_o,
   output reg stb_o,
   output reg we_o,
   output wire [3:0] sel_o,
   output reg [31:0] adr_o,
   output reg [31:0] dat_o
);
   assign sel_o = 4'hF;
   initial {cyc_o, stb_o, we_o, adr_o, dat_o} = 67'h0;
   task xfer(input w, input [7:0] idx, input [7:0] v, output [7:0] r);
      begin
         @(posedge clk_i);
         {cyc_o, stb_o} <= 2'h3;
         {we_o, adr_o, dat_o} <= {w, 22'h0, idx, 2'h0, 24'h0, v};
         @(posedge clk_i);
         // only the bench watchdog ends a wait for the answer
         while (ack_i !== 1'b1) begin
            @(posedge clk_i);
         end
         r = rdat_i[7:0];
         {cyc_o, stb_o} <= 2'h0;
      end
   endtask
   task flush;
      reg [7:0] d;
      integer k;
      begin
         xfer(1'b1, 8'h03, 8'h01, d);
         for (k = 0; k < 3;) begin
            @(posedge clk_i);
            k = k + tx_tick_i;
         end
         xfer(1'b1, 8'h03, 8'h00, d);
      end
   endtask
endmodule // sfr_host

//--- sim/sfr_top_tb.sv
/* bench for the register bank.
 assumes design/ on the include path. */
`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_top_tb;
   reg clk_i, rst_i, tick, pen, oen;
   reg [1:0] tc;
   reg [6:0] st;
   reg [7:0] r;
   wire cyc, stb, we, ack, flush, done, irq;
   wire [3:0] sel;
   wire [31:0] adr, wd, rd;
   integer n_mismatch, total_checks, k;
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      tc <= tc + 2'h1;
      tick <= tc == 2'h3;
   end
   sfr_host i_sfr_host (.clk_i(clk_i), .tx_tick_i(tick), .ack_i(ack), .rdat_i(rd),
      .cyc_o(cyc), .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wd));
   sfr_top #(.TAIL_CYC(9)) i_sfr_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
      .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .pattern_lock_flag_i(st[6]),
      .pattern_error_flag_i(st[5]), .ext_osc_lock_flag_i(st[4]), .signal_loss_flag_i(st[3]),
      .recovery_lock_flag_i(st[2]), .multiplier_lock_flag_i(st[1]), .overflow_flag_i(st[0]),
      .pattern_check_enable_i(pen), .ext_osc_lock_detect_enable_i(oen), .tx_tick_i(tick),
      .fifo_flush_o(flush), .flush_done_o(done), .irq_o(irq));
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task put(input [6:0] v, input integer w);
      begin
         @(posedge clk_i);
         st <= v;
         repeat (w) @(posedge clk_i);
      end
   endtask
   task t_ctrl;
      begin
         i_sfr_host.xfer(1'b0, `SFR_IDX_CTRL, 8'h00, r);
         chk("ctrl reset", 8'h00, r);
         i_sfr_host.xfer(1'b1, `SFR_IDX_CTRL, 8'hFC, r);
         i_sfr_host.xfer(1'b0, `SFR_IDX_CTRL, 8'h00, r);
         chk("ctrl reserved", 8'h00, r);
         i_sfr_host.xfer(1'b0, 8'h10, 8'h00, r);
         chk("unmapped", 8'h00, r);
      end
   endtask
   task t_stat;
      begin
         for (k = 0; k < 7; k = k + 1) begin
            put(7'h01 << k, 6);
            i_sfr_host.xfer(1'b0, `SFR_IDX_STATUS, 8'h00, r);
            chk("status", 8'h01 << k, r);
         end
         pen <= 1'b0;
         oen <= 1'b0;
         put(7'h7F, 6);
         i_sfr_host.xfer(1'b0, `SFR_IDX_STATUS, 8'h00, r);
         chk("gated status", 8'h0F, r);
      end
   endtask
   task t_flush;
      begin
         put(7'h01, 30);
         chk("no self flush", 8'h00, {7'h00, flush});
         i_sfr_host.flush;
         for (k = 0; flush === 1'b1 && k < 20;) begin
            @(posedge clk_i);
            k = k + tick;
         end
         chk("tail in range", 8'h01, {7'h00, k >= 8 && k <= 10});
         chk("flush done", 8'h01, {7'h00, done});
         put(7'h00, 6);
         i_sfr_host.xfer(1'b1, `SFR_IDX_CTRL, 8'h02, r);
         put(7'h01, 0);
         for (k = 0; flush !== 1'b1 && k < 40; k = k + 1) @(posedge clk_i);
         chk("auto flush", 8'h01, {7'h00, flush});
         put(7'h00, 80);
         i_sfr_host.xfer(1'b1, `SFR_IDX_CTRL, 8'h00, r);
      end
   endtask
   task t_irq;
      begin
         i_sfr_host.xfer(1'b0, `SFR_IDX_IRQ_STAT, 8'h00, r);
         chk("irq status", 8'h01, {7'h00, r[0]});
         chk("irq masked", 8'h00, {7'h00, irq});
         i_sfr_host.xfer(1'b1, `SFR_IDX_IRQ_MASK, 8'h01, r);
         repeat (3) @(posedge clk_i);
         chk("irq on", 8'h01, {7'h00, irq});
         i_sfr_host.xfer(1'b1, `SFR_IDX_IRQ_STAT, 8'h01, r);
         repeat (3) @(posedge clk_i);
         chk("irq cleared", 8'h00, {7'h00, irq});
         i_sfr_host.xfer(1'b1, `SFR_IDX_IRQ_MASK, 8'h00, r);
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_mismatch);
         if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      {n_mismatch, total_checks, tc, tick, st, pen, oen, rst_i} = 0;
      {pen, oen, rst_i} = 3'h7;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_ctrl;
      t_stat;
      t_flush;
      t_irq;
      complete_run;
   end
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      complete_run;
   end
endmodule // sfr_top_tb
bind sfr_top sfr_top_chk #(.TAIL_CYC(TAIL_CYC)) i_sfr_top_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .overflow_flag_i(overflow_flag_i),
   .tx_tick_i(tx_tick_i), .fifo_flush_o(fifo_flush_o), .flush_done_o(flush_done_o), .irq_o(irq_o));
